/* ims_pkg.sv */
// Package with constants, types and register map of the acknowledge/stop sequencer.
package ims_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    // System clock period in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS = 5;
    // One SCL period in nanoseconds.
    localparam int unsigned SCL_PERIOD_NS = 10000;
    // One SCL period in clock cycles, rounded up.
    localparam int unsigned SCL_PERIOD_CYC = (SCL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Half an SCL period in clock cycles, rounded up.
    localparam int unsigned SCL_HALF_CYC = (SCL_PERIOD_CYC + 1) / 2;
    // Source edges with SCL held low before a bus timeout is flagged.
    localparam int unsigned TMO_LIMIT_EDGES = 16;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] COUNT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] TMO_SEL_OFS = 8'h0C;

    // Field positions.
    localparam int unsigned ACK_VALUE_POS = 0;
    localparam int unsigned ACK_CNT_END_POS = 1;
    localparam int unsigned STOP_FLAG_POS = 0;
    localparam int unsigned TMO_FLAG_POS = 1;
    localparam int unsigned BUSY_POS = 2;

    // Reset values.
    localparam logic ACK_VALUE_RST = 1'b0;
    localparam logic ACK_CNT_END_RST = 1'b0;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [2:0] TMO_SEL_RST = 3'h0;

    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    // ==========================================================
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACK_LOW,
        ST_ACK_REL,
        ST_ACK_HIGH,
        ST_STOP_LOW,
        ST_STOP_REL
    } ims_st_e;

    // Open-drain pin drive; oe_n low while the pin is pulled.
    typedef struct packed {
        logic scl_out;
        logic scl_oe_n;
        logic sda_out;
        logic sda_oe_n;
    } ims_pins_s;

    // Timeout clock sources, all on the system clock.
    typedef struct packed {
        logic logic_cell4_output;
        logic logic_cell3_output;
        logic logic_cell2_output;
        logic logic_cell1_output;
        logic timer_six;
        logic timer_four;
        logic timer_two;
    } ims_src_s;

    // Complete state of the sequencer.
    typedef struct packed {
        ims_st_e st;
        logic [15:0] cnt;
        logic ack_cur;
        logic scl_rel;
        logic sda_rel;
        logic ack_value_bit;
        logic ack_value_at_count_end;
        logic [7:0] byte_counter;
        logic [2:0] timeout_source_field;
        logic stop_detected_flag;
        logic tmo_flag;
        logic [7:0] tmo_cnt;
        logic src_prev;
        logic sda_prev;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ims_state_s;

endpackage : ims_pkg

/* ims_sync.sv */
// Two-flop synchroniser for pin levels entering the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module ims_sync #(
    parameter int W = 2
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ==========================================================
    // Stages
    // ==========================================================
    // First stage feeds only the second; pins idle high.
    logic [1:0][W-1:0] stg;

    // Shift the pin levels through both stages.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stg <= '1;
        end else begin
            stg <= {stg[0], d};
        end
    end

    assign q = stg[1];

endmodule : ims_sync
`default_nettype wire

/* ims_ack_stop.sv */
// Acknowledge and stop sequencer of an I2C master with AXI4-Lite registers.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ims_ack_stop #(
    parameter int unsigned SCL_CYC = ims_pkg::SCL_PERIOD_CYC,
    parameter int unsigned HALF_CYC = ims_pkg::SCL_HALF_CYC,
    parameter int unsigned TMO_LIMIT = ims_pkg::TMO_LIMIT_EDGES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic byte_done,
    input wire logic scl_in,
    input wire logic sda_in,
    output ims_pkg::ims_pins_s pins,
    input wire ims_pkg::ims_src_s tmo_src,
    output logic seq_busy,
    output logic stop_detected,
    output logic bus_timeout
);

    // ==========================================================
    // Pin sampling
    // ==========================================================
    // Synchronised SCL and SDA levels.
    logic [1:0] pin_s;
    logic scl_s;
    logic sda_s;

    ims_sync #(.W(2)) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d({scl_in, sda_in}),
        .q(pin_s)
    );

    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    // ==========================================================
    // State
    // ==========================================================
    ims_pkg::ims_state_s r;
    ims_pkg::ims_state_s next_r;

    // Selected timeout source and its rising edge.
    logic [7:0] src_vec;
    logic src_sel;
    logic tmo_edge;
    // Write and read address decode.
    logic wr_do;
    logic rd_do;
    logic [7:0] rd_addr;

    // Handshake outputs are combinational from registered state.
    assign awready = !r.aw_got && !r.bvalid;
    assign wready = !r.w_got && !r.bvalid;
    assign arready = !r.rvalid;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    // Open-drain drive: data always low, only the enables move; one driver for the whole struct.
    assign pins = {1'b0, r.scl_rel, 1'b0, r.sda_rel};
    assign seq_busy = (r.st != ims_pkg::ST_IDLE);
    assign stop_detected = r.stop_detected_flag;
    assign bus_timeout = r.tmo_flag;

    // Next-state logic for sequencer, counters and register slave.
    always_comb begin
        next_r = r;
        // source selection
        // Code zero maps to a constant low, so it has no clock.
        src_vec = {tmo_src, 1'b0};
        src_sel = src_vec[r.timeout_source_field];
        tmo_edge = src_sel && !r.src_prev;
        next_r.src_prev = src_sel;
        next_r.sda_prev = sda_s;
        next_r.cnt = r.cnt + 16'h0001;

        // Byte counter decrements per byte, never past zero.
        if (byte_done && (r.byte_counter != 8'h00)) begin
            next_r.byte_counter = r.byte_counter - 8'h01;
        end

        unique case (r.st)
            ims_pkg::ST_IDLE: begin
                if (byte_done) begin
                    next_r.st = ims_pkg::ST_ACK_LOW;
                    next_r.cnt = 16'h0000;
                    next_r.ack_cur = (r.byte_counter <= 8'h01) ?
                        r.ack_value_at_count_end : r.ack_value_bit;
                end
            end
            ims_pkg::ST_ACK_LOW: begin
                if (r.cnt == 16'(SCL_CYC - 1)) begin
                    next_r.st = ims_pkg::ST_ACK_REL;
                end
            end
            ims_pkg::ST_ACK_REL: begin
                next_r.cnt = 16'h0000;
                if (scl_s) begin
                    next_r.st = ims_pkg::ST_ACK_HIGH;
                end
            end
            ims_pkg::ST_ACK_HIGH: begin
                if (r.cnt == 16'(SCL_CYC - 1)) begin
                    next_r.cnt = 16'h0000;
                    next_r.st = (r.byte_counter == 8'h00) ?
                        ims_pkg::ST_STOP_LOW : ims_pkg::ST_IDLE;
                end
            end
            ims_pkg::ST_STOP_LOW: begin
                if (r.cnt == 16'(HALF_CYC - 1)) begin
                    next_r.st = ims_pkg::ST_STOP_REL;
                end
            end
            ims_pkg::ST_STOP_REL: begin
                // release SDA once SCL is high
                if (scl_s) begin
                    next_r.st = ims_pkg::ST_IDLE;
                end
            end
        endcase

        // pin drive per state
        // SCL is pulled again for one cycle when the high phase ends into idle.
        next_r.scl_rel = !(next_r.st == ims_pkg::ST_ACK_LOW ||
                           next_r.st == ims_pkg::ST_IDLE && r.st == ims_pkg::ST_ACK_HIGH ||
                           next_r.st == ims_pkg::ST_STOP_LOW);
        // zero pulls SDA, one releases it
        next_r.sda_rel = !((next_r.st == ims_pkg::ST_ACK_LOW ||
                            next_r.st == ims_pkg::ST_ACK_REL ||
                            next_r.st == ims_pkg::ST_ACK_HIGH) && !next_r.ack_cur ||
                           next_r.st == ims_pkg::ST_STOP_LOW ||
                           next_r.st == ims_pkg::ST_STOP_REL && !scl_s);

        // Timeout counts source edges while SCL is held low.
        if (scl_s) begin
            next_r.tmo_cnt = 8'h00;
        end else if (tmo_edge && r.tmo_cnt != 8'(TMO_LIMIT)) begin
            next_r.tmo_cnt = r.tmo_cnt + 8'h01;
        end

        // Write channel: address and data in either order.
        if (awvalid && awready) begin
            next_r.aw_got = 1'b1;
            next_r.awaddr = awaddr[7:0];
        end
        if (wvalid && wready) begin
            next_r.w_got = 1'b1;
            next_r.wdata = wdata[7:0];
            next_r.wstrb0 = wstrb[0];
        end
        wr_do = r.aw_got && r.w_got;
        if (wr_do) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = ims_pkg::RESP_OKAY;
            unique case (r.awaddr)
                ims_pkg::CTRL_OFS: begin
                    if (r.wstrb0) begin
                        next_r.ack_value_bit = r.wdata[ims_pkg::ACK_VALUE_POS];
                        next_r.ack_value_at_count_end = r.wdata[ims_pkg::ACK_CNT_END_POS];
                    end
                end
                ims_pkg::COUNT_OFS: begin
                    if (r.wstrb0) begin
                        next_r.byte_counter = r.wdata;
                    end
                end
                ims_pkg::STATUS_OFS: begin
                    if (r.wstrb0 && r.wdata[ims_pkg::STOP_FLAG_POS]) begin
                        next_r.stop_detected_flag = 1'b0;
                    end
                    if (r.wstrb0 && r.wdata[ims_pkg::TMO_FLAG_POS]) begin
                        next_r.tmo_flag = 1'b0;
                    end
                end
                ims_pkg::TMO_SEL_OFS: begin
                    if (r.wstrb0) begin
                        next_r.timeout_source_field = r.wdata[2:0];
                    end
                end
                default: begin
                    next_r.bresp = ims_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (r.bvalid && bready) begin
            next_r.bvalid = 1'b0;
        end

        // stop detection, set wins over clear
        if (sda_s && !r.sda_prev && scl_s) begin
            next_r.stop_detected_flag = 1'b1;
        end
        if (r.timeout_source_field != 3'h0 && r.tmo_cnt == 8'(TMO_LIMIT)) begin
            next_r.tmo_flag = 1'b1;
        end

        // Read channel answers one cycle after the address.
        rd_do = arvalid && arready;
        rd_addr = araddr[7:0];
        if (rd_do) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = ims_pkg::RESP_OKAY;
            next_r.rdata = 32'h0000_0000;
            unique case (rd_addr)
                ims_pkg::CTRL_OFS: begin
                    next_r.rdata[ims_pkg::ACK_VALUE_POS] = r.ack_value_bit;
                    next_r.rdata[ims_pkg::ACK_CNT_END_POS] = r.ack_value_at_count_end;
                end
                ims_pkg::COUNT_OFS: begin
                    next_r.rdata[7:0] = r.byte_counter;
                end
                ims_pkg::STATUS_OFS: begin
                    next_r.rdata[ims_pkg::STOP_FLAG_POS] = r.stop_detected_flag;
                    next_r.rdata[ims_pkg::TMO_FLAG_POS] = r.tmo_flag;
                    next_r.rdata[ims_pkg::BUSY_POS] = seq_busy;
                end
                ims_pkg::TMO_SEL_OFS: begin
                    next_r.rdata[2:0] = r.timeout_source_field;
                end
                default: begin
                    next_r.rresp = ims_pkg::RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && rready) begin
            next_r.rvalid = 1'b0;
        end
    end

    // Register the whole state.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.st <= ims_pkg::ST_IDLE;
            r.scl_rel <= 1'b1;
            r.sda_rel <= 1'b1;
            r.sda_prev <= 1'b1;
            r.ack_value_bit <= ims_pkg::ACK_VALUE_RST;
            r.ack_value_at_count_end <= ims_pkg::ACK_CNT_END_RST;
            r.byte_counter <= ims_pkg::COUNT_RST;
            r.timeout_source_field <= ims_pkg::TMO_SEL_RST;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_byte_idle;
        byte_done && r.st == ims_pkg::ST_IDLE;
    endsequence
    sequence s_ack_entry;
        r.st == ims_pkg::ST_ACK_LOW && r.cnt == 16'h0000;
    endsequence

    ack_auto_start_a: assert property (s_byte_idle |=> s_ack_entry)
        else $error("Acknowledge did not start after byte.");
    ack_scl_low_a: assert property (r.st == ims_pkg::ST_ACK_LOW |-> !pins.scl_oe_n)
        else $error("SCL not pulled during acknowledge.");
    ack_sda_value_a: assert property (
        r.st == ims_pkg::ST_ACK_LOW |-> pins.sda_oe_n == r.ack_cur)
        else $error("SDA does not show acknowledge value.");
    ack_low_time_a: assert property (
        r.st == ims_pkg::ST_ACK_LOW ##1 r.st == ims_pkg::ST_ACK_REL
        |-> $past(r.cnt) == 16'(SCL_CYC - 1) && pins.scl_oe_n)
        else $error("SCL released at wrong time.");
    ack_stretch_a: assert property (
        r.st == ims_pkg::ST_ACK_REL && !scl_s |=> r.st == ims_pkg::ST_ACK_REL)
        else $error("High phase timed before SCL high.");
    ack_scl_pull_a: assert property (
        r.st == ims_pkg::ST_ACK_HIGH && r.cnt == 16'(SCL_CYC - 1) |=> !pins.scl_oe_n)
        else $error("SCL not pulled after high phase.");
    stop_on_zero_a: assert property (
        r.st == ims_pkg::ST_ACK_HIGH && r.cnt == 16'(SCL_CYC - 1) && r.byte_counter == 8'h00
        |=> r.st == ims_pkg::ST_STOP_LOW && !pins.sda_oe_n && !pins.scl_oe_n)
        else $error("Stop not generated at zero count.");
    stop_half_time_a: assert property (
        r.st == ims_pkg::ST_STOP_LOW ##1 r.st == ims_pkg::ST_STOP_REL
        |-> $past(r.cnt) == 16'(HALF_CYC - 1) && !pins.sda_oe_n)
        else $error("Stop SCL release timing wrong.");
    stop_flag_set_a: assert property (
        sda_s && !r.sda_prev && scl_s |=> r.stop_detected_flag)
        else $error("Stop detection flag not set.");
    tmo_reserved_a: assert property (
        r.timeout_source_field == 3'h0 && !r.tmo_flag |=> !r.tmo_flag)
        else $error("Timeout with reserved source.");

endmodule : ims_ack_stop
`default_nettype wire

/* ims_slave_model.sv */
// Slave-side bus model: pulled-up open-drain lines with clock stretching.
`timescale 1ns/1ps
`default_nettype none
module ims_slave_model (
    input wire logic ref_clk,
    input wire ims_pkg::ims_pins_s pins,
    input wire logic [7:0] stretch,
    input wire logic hold_low,
    output logic scl,
    output logic sda
);
    // Cycles of stretch still to run after the master lets SCL go.
    logic [7:0] left = 8'h00;
    // Last master drive of SCL, used to find the moment of release.
    logic prev_oe = 1'b1;
    // Release seen this cycle, so the line never glitches high before the stretch.
    logic rel_now;

    // ====================
    // Stretch timer
    // ====================
    // slave holds SCL
    always @(posedge ref_clk) begin
        prev_oe <= pins.scl_oe_n;
        if (pins.scl_oe_n && !prev_oe) begin
            left <= stretch;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end

    // ====================
    // Wired lines
    // ====================
    // Each line is high through its pull-up unless some party pulls it low.
    assign rel_now = pins.scl_oe_n && !prev_oe && (stretch != 8'h00);
    assign scl = pins.scl_oe_n && !hold_low && (left == 8'h00) && !rel_now;
    assign sda = pins.sda_oe_n;
endmodule : ims_slave_model
`default_nettype wire

/* ims_ack_stop_tb_top.sv */
// Directed bench for the acknowledge and stop sequencer over its register bus.
`timescale 1ns/1ps
`default_nettype none
module ims_ack_stop_tb_top;
    // Shortened counts keep the run brief.
    localparam int SCL_T = 20;
    localparam int HALF_T = 10;
    logic ref_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, byte_done, hold_low;
    logic awready, wready, bvalid, arready, rvalid, seq_busy, stop_detected, bus_timeout;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [6:0] tmo_src, sel;
    logic [7:0] stretch;
    logic scl, sda;
    ims_pkg::ims_pins_s pins;
    int n_mismatch, cmp_count, cyc;

    ims_ack_stop #(.SCL_CYC(SCL_T), .HALF_CYC(HALF_T), .TMO_LIMIT(4)) ims_ack_stop_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .byte_done(byte_done), .scl_in(scl), .sda_in(sda),
        .pins(pins), .tmo_src(ims_pkg::ims_src_s'(tmo_src)), .seq_busy(seq_busy),
        .stop_detected(stop_detected), .bus_timeout(bus_timeout));
    ims_slave_model ims_slave_model_inst (.ref_clk(ref_clk), .pins(pins),
        .stretch(stretch), .hold_low(hold_low), .scl(scl), .sda(sda));

    // ====================
    // Checking and closing
    // ====================
    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Prints the counts and the verdict, then stops.
    task automatic finish_test();
        $display("Mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    // A wait that ran out counts as a mismatch and ends the run.
    task automatic hang();
        n_mismatch++;
        $display("[ERR] %0t wait ran out", $time);
        finish_test();
    endtask : hang

    // ====================
    // Bus and pin tasks
    // ====================
    // One write; each channel drops when taken, the answer ends the task.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        @(posedge ref_clk);
        awaddr <= {24'h000000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge ref_clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            r = bresp;
            @(posedge ref_clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) begin
                bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask : bus_wr
    // One read; data and answer are taken at the handshake edge.
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t;
        @(posedge ref_clk);
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge ref_clk);
            ar_t = arvalid && arready;
            d = rdata;
            r = rresp;
            @(posedge ref_clk);
            if (ar_t) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask : bus_rd
    // Waits for one watched output to reach a level and returns the cycles taken.
    task automatic wait_for(input int s, input logic val, output int c);
        logic [4:0] v;
        for (c = 1; c <= 2000; c++) begin
            @(negedge ref_clk);
            v = {bus_timeout, seq_busy, stop_detected, pins.sda_oe_n, pins.scl_oe_n};
            if (v[s] === val) return;
        end
        hang();
    endtask : wait_for
    // Sends one finished-byte pulse from the shifter.
    task automatic pulse();
        @(posedge ref_clk);
        byte_done <= 1'b1;
        @(posedge ref_clk);
        byte_done <= 1'b0;
    endtask : pulse
    // Gives the chosen timeout sources a number of rising edges.
    task automatic src_edges(input logic [6:0] m);
        repeat (6) begin
            @(posedge ref_clk);
            tmo_src <= m;
            @(posedge ref_clk);
            tmo_src <= 7'h00;
        end
        repeat (4) @(posedge ref_clk);
    endtask : src_edges

    // ====================
    // Clock and scenarios
    // ====================
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready, byte_done, hold_low} = 8'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        tmo_src = 7'h00;
        stretch = 8'h00;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        // Every register reads zero after reset; an unmapped place answers an error.
        for (int i = 0; i < 4; i++) begin
            bus_rd(8'(i * 4), rd, resp);
            chk(rd, 32'h0);
        end
        bus_wr(8'h10, 32'hFF, resp);
        chk(resp, ims_pkg::RESP_SLVERR);
        bus_rd(8'h10, rd, resp);
        chk(resp, ims_pkg::RESP_SLVERR);
        bus_wr(ims_pkg::TMO_SEL_OFS, 32'hFFFFFFFF, resp);
        bus_rd(ims_pkg::TMO_SEL_OFS, rd, resp);
        chk(rd, 32'h7);
        // Plain ACK for the first byte with a stretching slave, NACK for the last.
        bus_wr(ims_pkg::CTRL_OFS, 32'h2, resp);
        bus_wr(ims_pkg::COUNT_OFS, 32'h2, resp);
        stretch <= 8'd32;
        pulse();
        wait_for(0, 1'b0, cyc);
        chk(cyc <= 2, 1);
        chk(pins.sda_oe_n, 1'b0);
        wait_for(0, 1'b1, cyc);
        chk(cyc >= SCL_T - 1 && cyc <= SCL_T + 1, 1);
        wait_for(0, 1'b0, cyc);
        chk(cyc >= 32 + SCL_T && cyc <= 38 + SCL_T, 1);
        wait_for(3, 1'b0, cyc);
        chk(stop_detected, 1'b0);
        bus_rd(ims_pkg::COUNT_OFS, rd, resp);
        chk(rd, 32'h1);
        stretch <= 8'h00;
        pulse();
        wait_for(0, 1'b0, cyc);
        chk(pins.sda_oe_n, 1'b1);
        wait_for(0, 1'b1, cyc);
        wait_for(0, 1'b0, cyc);
        wait_for(1, 1'b0, cyc);
        chk(cyc <= 3, 1);
        wait_for(0, 1'b1, cyc);
        chk(cyc >= HALF_T - 1 && cyc <= HALF_T + 2, 1);
        chk(pins.sda_oe_n, 1'b0);
        wait_for(1, 1'b1, cyc);
        chk(cyc >= 2 && cyc <= 5, 1);
        wait_for(2, 1'b1, cyc);
        chk(cyc <= 5, 1);
        bus_rd(ims_pkg::STATUS_OFS, rd, resp);
        chk(rd[0], 1'b1);
        bus_wr(ims_pkg::STATUS_OFS, 32'h1, resp);
        bus_rd(ims_pkg::STATUS_OFS, rd, resp);
        chk(rd, 32'h0);
        // Each timeout code counts only its own source; the reserved code never fires.
        for (int code = 0; code < 8; code++) begin
            sel = (code == 0) ? 7'h7F : 7'(7'h01 << (code - 1));
            @(posedge ref_clk);
            hold_low <= 1'b0;
            bus_wr(ims_pkg::TMO_SEL_OFS, 32'(code), resp);
            bus_wr(ims_pkg::STATUS_OFS, 32'h2, resp);
            hold_low <= 1'b1;
            src_edges(7'h7F ^ sel);
            @(negedge ref_clk);
            chk(bus_timeout, 1'b0);
            src_edges(sel);
            @(negedge ref_clk);
            chk(bus_timeout, code != 0);
        end
        finish_test();
    end
endmodule : ims_ack_stop_tb_top
`default_nettype wire
